// file: src/hprs_regs.sv
// Read-only APB register bank showing received audio clock and video info values.
// Assumes packet decode logic on clk_sys delivers one-cycle valid strobes with data.
//
// Functional notes
// - Capture the 20-bit audio cycle time stamp and show it to software.
// - Time stamp bits 19:12 at 0x7b, 11:4 at 0x7c, 3:0 in 0x7d high nibble.
// - Capture the 20-bit audio divider value and show it to software.
// - Divider bits 19:16 in 0x7d low nibble, 15:8 at 0x7e, 7:0 at 0x7f.
// - Pixel encoding in 0x81 bits 6:5: RGB, 4:2:2 or 4:4:4.
// - Bit 4 of 0x81 is one when active format information is valid.
// - Bar information validity in 0x81 bits 3:2.
// - Scan information in 0x81 bits 1:0.
// - Colorimetry in 0x82 bits 7:6.
//
// Chosen here: the APB slave port.
`timescale 1ns/10ps
module hprs_regs (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // APB slave
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Audio clock regeneration packet
  input wire logic acr_valid,
  input wire logic [19:0] acr_time_stamp,
  input wire logic [19:0] acr_divider,
  // Video info packet
  input wire logic avi_valid,
  input wire logic [7:0] avi_version,
  input wire logic [1:0] avi_pixel_encoding,
  input wire logic avi_format_present,
  input wire logic [1:0] avi_bar_info,
  input wire logic [1:0] avi_scan_info,
  input wire logic [1:0] avi_colorimetry,
  input wire logic [1:0] avi_picture_aspect
);

  // An address is mapped when word aligned, upper bits clear and index in the bank.
  function automatic logic reg_mapped(input logic [11:0] addr);
    logic [7:0] idx;
    idx = addr[hprs_pkg::HPRS_IDX_LSB +: hprs_pkg::HPRS_IDX_W];
    reg_mapped = (addr[hprs_pkg::HPRS_IDX_LSB-1:0] == hprs_pkg::HPRS_ALIGN_OK)
                 && (addr[hprs_pkg::HPRS_ADDR_W-1 -: hprs_pkg::HPRS_TOP_W] == '0)
                 && (idx >= hprs_pkg::HPRS_IDX_TS_HIGH)
                 && (idx <= hprs_pkg::HPRS_IDX_COLOR_ASPECT);
  endfunction

  // Selects the byte shown at one index; unused and reserved bits read as zero.
  function automatic logic [7:0] read_byte(
    input logic [7:0] idx,
    input logic [19:0] ts,
    input logic [19:0] div,
    input hprs_pkg::hprs_avi_t avi
  );
    logic [7:0] b;
    b = hprs_pkg::HPRS_BYTE_ZERO;
    if (idx == hprs_pkg::HPRS_IDX_TS_HIGH) begin
      b = ts[hprs_pkg::HPRS_TS_HIGH_LSB +: hprs_pkg::HPRS_BYTE_W];
    end else if (idx == hprs_pkg::HPRS_IDX_TS_MID) begin
      b = ts[hprs_pkg::HPRS_TS_MID_LSB +: hprs_pkg::HPRS_BYTE_W];
    end else if (idx == hprs_pkg::HPRS_IDX_TS_LOW_DIV_HIGH) begin
      b = {ts[hprs_pkg::HPRS_TS_LOW_LSB +: hprs_pkg::HPRS_NIB_W],
           div[hprs_pkg::HPRS_DIV_HIGH_LSB +: hprs_pkg::HPRS_NIB_W]};
    end else if (idx == hprs_pkg::HPRS_IDX_DIV_MID) begin
      b = div[hprs_pkg::HPRS_DIV_MID_LSB +: hprs_pkg::HPRS_BYTE_W];
    end else if (idx == hprs_pkg::HPRS_IDX_DIV_LOW) begin
      b = div[hprs_pkg::HPRS_DIV_LOW_LSB +: hprs_pkg::HPRS_BYTE_W];
    end else if (idx == hprs_pkg::HPRS_IDX_VERSION) begin
      b = avi.version;
    end else if (idx == hprs_pkg::HPRS_IDX_FORMAT) begin
      b[hprs_pkg::HPRS_ENC_LSB +: hprs_pkg::HPRS_FIELD_W] = avi.enc;
      b[hprs_pkg::HPRS_AFI_BIT] = avi.afi;
      b[hprs_pkg::HPRS_BAR_LSB +: hprs_pkg::HPRS_FIELD_W] = avi.bar;
      b[hprs_pkg::HPRS_SCAN_LSB +: hprs_pkg::HPRS_FIELD_W] = avi.scan;
    end else if (idx == hprs_pkg::HPRS_IDX_COLOR_ASPECT) begin
      b[hprs_pkg::HPRS_COLOR_LSB +: hprs_pkg::HPRS_FIELD_W] = avi.color;
      b[hprs_pkg::HPRS_ASPECT_LSB +: hprs_pkg::HPRS_FIELD_W] = avi.aspect;
    end
    read_byte = b;
  endfunction

  hprs_cap_if cap ();

  hprs_capture u_capture (
    .clk_sys(clk_sys),
    .reset(reset),
    .cap(cap)
  );

  // Receiver fields arrive on clk_sys, so they feed the store without synchronisers.
  assign cap.acr_load = acr_valid;
  assign cap.acr_ts_in = acr_time_stamp;
  assign cap.acr_div_in = acr_divider;
  assign cap.avi_load = avi_valid;
  assign cap.avi_in.version = avi_version;
  assign cap.avi_in.enc = hprs_pkg::hprs_enc_t'(avi_pixel_encoding);
  assign cap.avi_in.afi = avi_format_present;
  assign cap.avi_in.bar = hprs_pkg::hprs_bar_t'(avi_bar_info);
  assign cap.avi_in.scan = hprs_pkg::hprs_scan_t'(avi_scan_info);
  assign cap.avi_in.color = hprs_pkg::hprs_color_t'(avi_colorimetry);
  assign cap.avi_in.aspect = avi_picture_aspect;

  // Bus decode.
  logic [7:0] idx_w;
  logic mapped_w;
  logic access_w;
  logic [7:0] byte_w;
  logic [31:0] rd_word_w;
  logic err_w;

  assign idx_w = paddr[hprs_pkg::HPRS_IDX_LSB +: hprs_pkg::HPRS_IDX_W];
  assign mapped_w = reg_mapped(paddr);
  assign access_w = psel && penable && !pready;
  assign byte_w = read_byte(idx_w, cap.ts, cap.div, cap.avi_q);
  // Writes to mapped registers are answered without error but change nothing.
  assign rd_word_w = (mapped_w && !pwrite) ? {{hprs_pkg::HPRS_PAD_W{1'b0}}, byte_w}
                                           : '0;
  assign err_w = !mapped_w;

  // Slave answers one cycle into the access phase, with data from flip-flops.
  hprs_pkg::hprs_apb_st_t state;
  hprs_pkg::hprs_apb_st_t next_state;
  logic next_pready;
  logic [31:0] next_prdata;
  logic next_pslverr;

  always_comb begin
    next_state = state;
    next_pready = 1'b0;
    next_prdata = '0;
    next_pslverr = 1'b0;
    case (state)
      hprs_pkg::HPRS_ST_IDLE: begin
        if (access_w) begin
          next_state = hprs_pkg::HPRS_ST_ANSWER;
          next_pready = 1'b1;
          next_prdata = rd_word_w;
          next_pslverr = err_w;
        end
      end
      hprs_pkg::HPRS_ST_ANSWER: begin
        next_state = hprs_pkg::HPRS_ST_IDLE;
      end
      default: begin
        next_state = hprs_pkg::HPRS_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      state <= hprs_pkg::HPRS_ST_IDLE;
      pready <= 1'b0;
      prdata <= '0;
      pslverr <= 1'b0;
    end else begin
      state <= next_state;
      pready <= next_pready;
      prdata <= next_prdata;
      pslverr <= next_pslverr;
    end
  end

  // Multi-byte values are not latched per read, so a packet between reads can tear them.

  // Checks.
  logic [7:0] exp_ts_high;
  logic [7:0] exp_ts_mid;
  logic [7:0] exp_mixed;
  logic [7:0] exp_div_mid;
  logic [7:0] exp_div_low;

  assign exp_ts_high = cap.ts[19:12];
  assign exp_ts_mid = cap.ts[11:4];
  assign exp_mixed = {cap.ts[3:0], cap.div[19:16]};
  assign exp_div_mid = cap.div[15:8];
  assign exp_div_low = cap.div[7:0];

  sequence s_read(logic [7:0] idx);
    access_w && !pwrite && mapped_w && (idx_w == idx);
  endsequence

  sequence s_write_mapped;
    access_w && pwrite && mapped_w;
  endsequence

  property p_read_byte(logic [7:0] idx, logic [7:0] exp);
    @(posedge clk_sys) disable iff (reset)
      s_read(idx) |=> pready && !pslverr && (prdata[7:0] == $past(exp))
                      && (prdata[31:8] == '0);
  endproperty

  AST_TS_CAPTURE: assert property (
    @(posedge clk_sys) disable iff (reset)
      acr_valid |=> (cap.ts == $past(acr_time_stamp)))
    else $error("time stamp not captured");

  AST_TS_HIGH: assert property (p_read_byte(8'h7b, exp_ts_high))
    else $error("time stamp high byte wrong");

  AST_TS_MID: assert property (p_read_byte(8'h7c, exp_ts_mid))
    else $error("time stamp middle byte wrong");

  AST_DIV_CAPTURE: assert property (
    @(posedge clk_sys) disable iff (reset)
      acr_valid ##1 !acr_valid |-> (cap.div == $past(acr_divider, 1)) ##1 $stable(cap.div))
    else $error("divider not captured or not held");

  AST_MIXED: assert property (p_read_byte(8'h7d, exp_mixed))
    else $error("shared nibble byte wrong");

  AST_DIV_MID: assert property (p_read_byte(8'h7e, exp_div_mid))
    else $error("divider middle byte wrong");

  AST_DIV_LOW: assert property (p_read_byte(8'h7f, exp_div_low))
    else $error("divider low byte wrong");

  AST_ENC: assert property (
    @(posedge clk_sys) disable iff (reset)
      avi_valid ##1 s_read(8'h81) |=> (prdata[6:5] == $past(avi_pixel_encoding, 2)))
    else $error("pixel encoding field wrong");

  AST_AFI: assert property (
    @(posedge clk_sys) disable iff (reset)
      s_read(8'h81) |=> (prdata[4] == $past(cap.avi_q.afi)) && !prdata[7])
    else $error("active format flag wrong");

  AST_BAR: assert property (
    @(posedge clk_sys) disable iff (reset)
      avi_valid ##1 s_read(8'h81) |=> (prdata[3:2] == $past(avi_bar_info, 2)))
    else $error("bar information field wrong");

  AST_SCAN: assert property (
    @(posedge clk_sys) disable iff (reset)
      avi_valid ##1 s_read(8'h81) |=> (prdata[1:0] == $past(avi_scan_info, 2)))
    else $error("scan information field wrong");

  AST_COLOR: assert property (
    @(posedge clk_sys) disable iff (reset)
      avi_valid ##1 s_read(8'h82) |=> (prdata[7:6] == $past(avi_colorimetry, 2))
                                      && (prdata[3:0] == 4'h0))
    else $error("colorimetry field wrong");

  AST_ASPECT: assert property (
    @(posedge clk_sys) disable iff (reset)
      avi_valid ##1 s_read(8'h82) |=> (prdata[5:4] == $past(avi_picture_aspect, 2)))
    else $error("picture aspect field wrong");

  AST_WRITE_IGNORED: assert property (
    @(posedge clk_sys) disable iff (reset)
      (s_write_mapped and (!acr_valid && !avi_valid)) |=> pready && !pslverr
        && (prdata == '0) && $stable(cap.ts) && $stable(cap.div) && $stable(cap.avi_q))
    else $error("write changed a read-only register");

  AST_UNMAPPED: assert property (
    @(posedge clk_sys) disable iff (reset)
      access_w && !reg_mapped(paddr) |=> pready && pslverr && (prdata == '0))
    else $error("unmapped access not refused");

  AST_ANSWER_PULSE: assert property (
    @(posedge clk_sys) disable iff (reset)
      access_w |=> pready ##1 !pready)
    else $error("ready not a single-cycle answer");

endmodule

// file: pkg/hprs_pkg.sv
// Constants and types shared by the received packet status register bank.
// Assumes a 32-bit APB slave with one aligned word per register index.
package hprs_pkg;
  localparam int HPRS_ADDR_W = 12;
  localparam int HPRS_DATA_W = 32;
  localparam int HPRS_BYTE_W = 8;
  localparam int HPRS_ACR_W = 20;
  localparam int HPRS_IDX_W = 8;
  localparam int HPRS_IDX_LSB = 2;
  localparam int HPRS_NIB_W = 4;
  localparam int HPRS_FIELD_W = 2;
  localparam int HPRS_PAD_W = HPRS_DATA_W - HPRS_BYTE_W;
  localparam int HPRS_TOP_W = HPRS_ADDR_W - HPRS_IDX_W - HPRS_IDX_LSB;

  // Register indices; the byte address is four times the index.
  localparam logic [7:0] HPRS_IDX_TS_HIGH = 8'h7b;
  localparam logic [7:0] HPRS_IDX_TS_MID = 8'h7c;
  localparam logic [7:0] HPRS_IDX_TS_LOW_DIV_HIGH = 8'h7d;
  localparam logic [7:0] HPRS_IDX_DIV_MID = 8'h7e;
  localparam logic [7:0] HPRS_IDX_DIV_LOW = 8'h7f;
  localparam logic [7:0] HPRS_IDX_VERSION = 8'h80;
  localparam logic [7:0] HPRS_IDX_FORMAT = 8'h81;
  localparam logic [7:0] HPRS_IDX_COLOR_ASPECT = 8'h82;

  // Field positions.
  localparam int HPRS_TS_HIGH_LSB = 12;
  localparam int HPRS_TS_MID_LSB = 4;
  localparam int HPRS_TS_LOW_LSB = 0;
  localparam int HPRS_DIV_HIGH_LSB = 16;
  localparam int HPRS_DIV_MID_LSB = 8;
  localparam int HPRS_DIV_LOW_LSB = 0;
  localparam int HPRS_ENC_LSB = 5;
  localparam int HPRS_AFI_BIT = 4;
  localparam int HPRS_BAR_LSB = 2;
  localparam int HPRS_SCAN_LSB = 0;
  localparam int HPRS_COLOR_LSB = 6;
  localparam int HPRS_ASPECT_LSB = 4;

  typedef enum logic [1:0] {
    HPRS_ENC_RGB = 2'h0, HPRS_ENC_422 = 2'h1, HPRS_ENC_444 = 2'h2, HPRS_ENC_RSVD = 2'h3
  } hprs_enc_t;
  typedef enum logic [1:0] {
    HPRS_BAR_NONE = 2'h0, HPRS_BAR_HORIZ = 2'h1, HPRS_BAR_VERT = 2'h2, HPRS_BAR_BOTH = 2'h3
  } hprs_bar_t;
  typedef enum logic [1:0] {
    HPRS_SCAN_NONE = 2'h0, HPRS_SCAN_OVER = 2'h1, HPRS_SCAN_UNDER = 2'h2, HPRS_SCAN_RSVD = 2'h3
  } hprs_scan_t;
  typedef enum logic [1:0] {
    HPRS_COLOR_NONE = 2'h0, HPRS_COLOR_SD = 2'h1, HPRS_COLOR_HD = 2'h2, HPRS_COLOR_RSVD = 2'h3
  } hprs_color_t;
  typedef logic [1:0] hprs_aspect_t;
  localparam hprs_aspect_t HPRS_ASPECT_NONE = 2'h0;

  typedef struct packed {
    logic [7:0] version;
    hprs_enc_t enc;
    logic afi;
    hprs_bar_t bar;
    hprs_scan_t scan;
    hprs_color_t color;
    hprs_aspect_t aspect;
  } hprs_avi_t;

  typedef enum logic [0:0] {HPRS_ST_IDLE, HPRS_ST_ANSWER} hprs_apb_st_t;

  localparam logic [19:0] HPRS_ACR_RESET = 20'h00000;
  localparam hprs_avi_t HPRS_AVI_RESET = '{8'h00, HPRS_ENC_RGB, 1'b0, HPRS_BAR_NONE,
                                           HPRS_SCAN_NONE, HPRS_COLOR_NONE, HPRS_ASPECT_NONE};
  localparam logic [7:0] HPRS_BYTE_ZERO = 8'h00;
  localparam logic [1:0] HPRS_ALIGN_OK = 2'h0;
endpackage

// file: pkg/hprs_cap_if.sv
// Carrier between the register front end and the capture store.
// Assumes both ends run on the same clock.
`timescale 1ns/10ps
interface hprs_cap_if;
  logic acr_load;
  logic [19:0] acr_ts_in;
  logic [19:0] acr_div_in;
  logic avi_load;
  hprs_pkg::hprs_avi_t avi_in;
  logic [19:0] ts;
  logic [19:0] div;
  hprs_pkg::hprs_avi_t avi_q;

  modport writer (
    output acr_load, acr_ts_in, acr_div_in, avi_load, avi_in,
    input ts, div, avi_q
  );
  modport store (
    input acr_load, acr_ts_in, acr_div_in, avi_load, avi_in,
    output ts, div, avi_q
  );
endinterface

// file: src/hprs_capture.sv
// Holds the latest audio clock regeneration values and video info fields.
// Assumes load strobes are one-cycle pulses on clk_sys with data valid alongside.
`timescale 1ns/10ps
module hprs_capture (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // Capture carrier
  hprs_cap_if.store cap
);

  // Each packet overwrites the previous one whole, so fields of one packet stay together.
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      cap.ts <= hprs_pkg::HPRS_ACR_RESET;
      cap.div <= hprs_pkg::HPRS_ACR_RESET;
    end else if (cap.acr_load) begin
      cap.ts <= cap.acr_ts_in;
      cap.div <= cap.acr_div_in;
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      cap.avi_q <= hprs_pkg::HPRS_AVI_RESET;
    end else if (cap.avi_load) begin
      cap.avi_q <= cap.avi_in;
    end
  end

endmodule

// file: verif/tb.sv
// Self-checking bench for the read-only packet status register bank.
// Assumes the bench alone drives the APB and packet ports on clk_sys at 125 MHz.
`timescale 1ns/10ps
module tb;
  logic clk_sys;
  logic reset;
  logic [11:0] paddr;
  logic psel;
  logic penable;
  logic pwrite;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic acr_valid;
  logic [19:0] acr_time_stamp;
  logic [19:0] acr_divider;
  logic avi_valid;
  logic [7:0] avi_version;
  logic [1:0] avi_pixel_encoding;
  logic avi_format_present;
  logic [1:0] avi_bar_info;
  logic [1:0] avi_scan_info;
  logic [1:0] avi_colorimetry;
  logic [1:0] avi_picture_aspect;
  logic [31:0] rdata;
  logic rerr;
  int fail_count = 0;
  int n_checks = 0;
  int cyc = 0;

  hprs_regs uut (
    .clk_sys(clk_sys),
    .reset(reset),
    .paddr(paddr),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .acr_valid(acr_valid),
    .acr_time_stamp(acr_time_stamp),
    .acr_divider(acr_divider),
    .avi_valid(avi_valid),
    .avi_version(avi_version),
    .avi_pixel_encoding(avi_pixel_encoding),
    .avi_format_present(avi_format_present),
    .avi_bar_info(avi_bar_info),
    .avi_scan_info(avi_scan_info),
    .avi_colorimetry(avi_colorimetry),
    .avi_picture_aspect(avi_picture_aspect)
  );

  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  task automatic close_out;
    $display("checks %0d errors %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // The whole run needs well under a thousand cycles; a hang stops here.
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 3000) begin
      fail_count++;
      $display("ERROR %0t timeout", $time);
      close_out();
    end
  end

  function automatic logic [11:0] adr(input logic [7:0] idx);
    return {2'h0, idx, 2'h0};
  endfunction

  task automatic chk_data(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %0t read data %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_err(input logic got, input logic exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %0t slave error %b expected %b", $time, got, exp);
    end
  endtask

  // One APB transfer; the request is held until pready is seen high at an edge.
  // Only the bench timeout ends a wait for an answer that never comes.
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
    end while (pready !== 1'b1);
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, input logic [7:0] b, input logic e);
    apb(a, 1'b0, 32'h00000000);
    chk_data(rdata, {24'h000000, b});
    chk_err(rerr, e);
  endtask

  task automatic send_acr(input logic [19:0] ts, input logic [19:0] dv);
    @(posedge clk_sys);
    acr_valid <= 1'b1;
    acr_time_stamp <= ts;
    acr_divider <= dv;
    @(posedge clk_sys);
    acr_valid <= 1'b0;
    acr_time_stamp <= ~ts;
    acr_divider <= ~dv;
  endtask

  task automatic chk_acr(input logic [19:0] ts, input logic [19:0] dv);
    rd(adr(hprs_pkg::HPRS_IDX_TS_HIGH), ts[19:12], 1'b0);
    rd(adr(hprs_pkg::HPRS_IDX_TS_MID), ts[11:4], 1'b0);
    rd(adr(hprs_pkg::HPRS_IDX_TS_LOW_DIV_HIGH), {ts[3:0], dv[19:16]}, 1'b0);
    rd(adr(hprs_pkg::HPRS_IDX_DIV_MID), dv[15:8], 1'b0);
    rd(adr(hprs_pkg::HPRS_IDX_DIV_LOW), dv[7:0], 1'b0);
  endtask

  task automatic avi_pkt(input logic [1:0] c);
    @(posedge clk_sys);
    avi_valid <= 1'b1;
    avi_version <= {c, 6'h15};
    {avi_pixel_encoding, avi_bar_info, avi_scan_info} <= {c, c, c};
    {avi_colorimetry, avi_picture_aspect, avi_format_present} <= {c, c, c[0]};
    @(posedge clk_sys);
    avi_valid <= 1'b0;
    avi_version <= 8'hff;
    avi_format_present <= ~c[0];
  endtask

  // Every two-bit field of one video packet takes the same code, so each code is seen once.
  // A packet goes out with the setup cycle of a read, so that read is taken one cycle later.
  task automatic avi_step(input logic [1:0] c, input logic send);
    if (send) begin
      fork
        avi_pkt(c);
        rd(adr(hprs_pkg::HPRS_IDX_FORMAT), {1'b0, c, c[0], c, c}, 1'b0);
      join
      fork
        avi_pkt(c);
        rd(adr(hprs_pkg::HPRS_IDX_COLOR_ASPECT), {c, c, 4'h0}, 1'b0);
      join
    end else begin
      rd(adr(hprs_pkg::HPRS_IDX_FORMAT), {1'b0, c, c[0], c, c}, 1'b0);
      rd(adr(hprs_pkg::HPRS_IDX_COLOR_ASPECT), {c, c, 4'h0}, 1'b0);
    end
    rd(adr(hprs_pkg::HPRS_IDX_VERSION), {c, 6'h15}, 1'b0);
  endtask

  initial begin
    reset = 1'b1;
    {paddr, psel, penable, pwrite, pwdata} = '0;
    {acr_valid, acr_time_stamp, acr_divider} = '0;
    {avi_valid, avi_version, avi_pixel_encoding, avi_format_present} = '0;
    {avi_bar_info, avi_scan_info, avi_colorimetry, avi_picture_aspect} = '0;
    repeat (4) @(posedge clk_sys);
    reset <= 1'b0;
    for (int i = 8'h7b; i <= 8'h82; i++) begin
      rd(adr(i[7:0]), 8'h00, 1'b0);
    end
    send_acr(20'habcde, 20'h12345);
    chk_acr(20'habcde, 20'h12345);
    send_acr(20'h54321, 20'hedcba);
    chk_acr(20'h54321, 20'hedcba);
    for (int i = 0; i < 4; i++) begin
      avi_step(i[1:0], 1'b1);
    end
    // Writes to every mapped register complete cleanly and change nothing.
    for (int i = 8'h7b; i <= 8'h82; i++) begin
      apb(adr(i[7:0]), 1'b1, 32'h5a5a5a5a);
      chk_err(rerr, 1'b0);
      chk_data(rdata, 32'h00000000);
    end
    chk_acr(20'h54321, 20'hedcba);
    avi_step(2'h3, 1'b0);
    rd(adr(8'h7a), 8'h00, 1'b1);
    rd(adr(8'h83), 8'h00, 1'b1);
    rd(12'h1ed, 8'h00, 1'b1);
    rd(12'h5ec, 8'h00, 1'b1);
    apb(adr(8'h83), 1'b1, 32'hffffffff);
    chk_err(rerr, 1'b1);
    chk_data(rdata, 32'h00000000);
    @(posedge clk_sys);
    reset <= 1'b1;
    repeat (2) @(posedge clk_sys);
    reset <= 1'b0;
    chk_acr(20'h00000, 20'h00000);
    close_out();
  end
endmodule
